// file: rtl/mfio_fall_detect.sv
// Falling-edge detector on a synchronous pin level
module mfio_fall_detect
    import mfio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Level in, edge out
    input wire logic level,
    output logic fall
);

    logic last_level;

    // Previous level, loaded high at reset, so a pin low at reset release flags a fall
    always_ff @(posedge clk) begin
        if (reset) begin
            last_level <= 1'b1;
        end else begin
            last_level <= level;
        end
    end

    // High then low
    assign fall = last_level & ~level;

endmodule : mfio_fall_detect

// file: rtl/mfio_pin_drive.sv
// Per-pin output stage: open-drain or push-pull, gated by enable
module mfio_pin_drive
    import mfio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Register state
    input wire logic [WIDTH-1:0] latch,
    input wire logic [WIDTH-1:0] push_pull,
    input wire logic [WIDTH-1:0] enable,
    // Pin drive
    output logic [WIDTH-1:0] out,
    output logic [WIDTH-1:0] oe
);

    // Open-drain pins only ever sink; push-pull pins follow the latch
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (push_pull[i]) begin
                out[i] = latch[i]; // RQ5
                oe[i] = enable[i];
            end else begin
                out[i] = 1'b0; // RQ21
                oe[i] = enable[i] & ~latch[i]; // RQ21
            end
        end
    end

endmodule : mfio_pin_drive

// file: rtl/mfio_pkg.sv
// Constants, types and register map of the multi-function I/O port block
//
// Operation
// RQ1 - Output pins hold value in output latch
// RQ2 - Port read samples pins in first state
// RQ3 - Port write updates pins in second state
// RQ4 - Reset: port A latch ones, drive zero
// RQ5 - Drive bit zero open-drain, one push-pull
// RQ6 - Inputs need latch one, then drive zero
// RQ7 - Transmit or high output keeps latch one
// RQ8 - Port A latch and pin reads separate
// RQ9 - Port B direction one output, zero input
// RQ10 - Reset: port B direction and latch zero
// RQ11 - Port B read: latch outputs, pins inputs
// RQ12 - Read-modify-write stores input pin levels back
// RQ13 - Timer output needs latch one, direction one
// RQ14 - Ports A, B eight bits; C three
// RQ15 - Reset: port C latch all ones
// RQ16 - Port C inputs keep latch at one
// RQ17 - Dual-clock mode gives upper C pins oscillator
// RQ18 - Falling edge on lowest C pin flagged
// RQ19 - Port C latch, pin reads; upper bits zero
// RQ20 - Stop mode floats lowest C pin always
// RQ21 - Open-drain: latch zero sinks, one releases
package mfio_pkg;

    // Widths
    localparam int MFIO_ADDR_W = 6;
    localparam int MFIO_DATA_W = 8;
    localparam int MFIO_PORT_A_W = 8;
    localparam int MFIO_PORT_B_W = 8;
    localparam int MFIO_PORT_C_W = 3; // RQ14

    // Register offsets
    localparam logic [5:0] MFIO_PORT_A_OUTPUT_LATCH = 6'h00;
    localparam logic [5:0] MFIO_PORT_B_OUTPUT_LATCH = 6'h01;
    localparam logic [5:0] MFIO_PORT_C_OUTPUT_LATCH = 6'h02;
    localparam logic [5:0] MFIO_PORT_A_DRIVE_SELECT = 6'h08;
    localparam logic [5:0] MFIO_PORT_B_DIRECTION = 6'h09;
    localparam logic [5:0] MFIO_PORT_A_PIN_LEVELS = 6'h0b;
    localparam logic [5:0] MFIO_PORT_C_PIN_LEVELS = 6'h0c;

    // Reset values
    localparam logic [7:0] MFIO_PORT_A_LATCH_RESET = 8'hff;
    localparam logic [7:0] MFIO_PORT_A_DRIVE_RESET = 8'h00;
    localparam logic [7:0] MFIO_PORT_B_LATCH_RESET = 8'h00;
    localparam logic [7:0] MFIO_PORT_B_DIR_RESET = 8'h00;
    localparam logic [2:0] MFIO_PORT_C_LATCH_RESET = 3'h7;
    localparam logic [7:0] MFIO_READ_IDLE = 8'h00;

    // Port C pin positions
    localparam int MFIO_STOP_RELEASE_BIT = 0;
    localparam int MFIO_OSC_IN_BIT = 1;
    localparam int MFIO_OSC_OUT_BIT = 2;

    // Register bus request
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mfio_bus_req_type;

    // Drive of an eight-bit port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } mfio_wide_pins_type;

    // Drive of the three-bit port
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } mfio_narrow_pins_type;

endpackage : mfio_pkg

// file: rtl/mfio_ports.sv
// Three parallel I/O ports: register file, pin drive and pin sampling
module mfio_ports
    import mfio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire mfio_bus_req_type bus_req,
    output logic [7:0] rdata,
    // Chip-level controls
    input wire logic global_output_enable,
    input wire logic dual_clock_mode,
    input wire logic stop_mode,
    // Port A pins
    input wire logic [7:0] port_a_in,
    output mfio_wide_pins_type port_a_pins,
    // Port B pins
    input wire logic [7:0] port_b_in,
    output mfio_wide_pins_type port_b_pins,
    // Port C pins
    input wire logic [2:0] port_c_in,
    output mfio_narrow_pins_type port_c_pins,
    // Secondary functions
    output logic low_freq_osc_connect,
    output logic stop_release_fall
);

    // Register state
    logic [7:0] port_a_output_latch;
    logic [7:0] port_a_drive_select;
    logic [7:0] port_b_output_latch;
    logic [7:0] port_b_direction;
    logic [2:0] port_c_output_latch;

    // Next values
    logic [7:0] next_rdata;
    logic [7:0] next_port_b_read;
    logic [2:0] next_port_c_enable;
    mfio_wide_pins_type next_port_a_pins;
    mfio_wide_pins_type next_port_b_pins;
    mfio_narrow_pins_type next_port_c_pins;
    logic [7:0] next_port_a_output_latch;
    logic [7:0] next_port_a_drive_select;
    logic [7:0] next_port_b_output_latch;
    logic [7:0] next_port_b_direction;
    logic [2:0] next_port_c_output_latch;

    // Raw output-stage results
    logic [7:0] a_out;
    logic [7:0] a_oe;
    logic [7:0] b_out;
    logic [7:0] b_oe;
    logic [2:0] c_out;
    logic [2:0] c_oe;
    logic c_fall;

    // Decoded write strobes
    logic wr_a_latch;
    logic wr_a_drive;
    logic wr_b_latch;
    logic wr_b_dir;
    logic wr_c_latch;

    // Decoded read strobes
    logic rd_a_latch;
    logic rd_a_drive;
    logic rd_a_pins;
    logic rd_b_data;
    logic rd_b_dir;
    logic rd_c_latch;
    logic rd_c_pins;

    // Write decode for one register
    function automatic logic write_hit(input mfio_bus_req_type req, input logic [5:0] offset);
        write_hit = req.wr & (req.addr == offset);
    endfunction : write_hit

    // Read decode for one register
    function automatic logic read_hit(input mfio_bus_req_type req, input logic [5:0] offset);
        read_hit = req.rd & (req.addr == offset);
    endfunction : read_hit

    // Narrow port value placed in the low bits of a byte, upper bits zero
    function automatic logic [7:0] widen_c(input logic [2:0] value);
        widen_c = {5'h00, value};
    endfunction : widen_c

    // Per-bit choice between latch and live pin
    function automatic logic [7:0] select_bits(
        input logic [7:0] sel,
        input logic [7:0] when_one,
        input logic [7:0] when_zero
    );
        select_bits = (sel & when_one) | (~sel & when_zero);
    endfunction : select_bits

    // Strobe decode
    assign wr_a_latch = write_hit(bus_req, MFIO_PORT_A_OUTPUT_LATCH);
    assign wr_a_drive = write_hit(bus_req, MFIO_PORT_A_DRIVE_SELECT);
    assign wr_b_latch = write_hit(bus_req, MFIO_PORT_B_OUTPUT_LATCH);
    assign wr_b_dir = write_hit(bus_req, MFIO_PORT_B_DIRECTION);
    assign wr_c_latch = write_hit(bus_req, MFIO_PORT_C_OUTPUT_LATCH);

    // Read strobe decode
    assign rd_a_latch = read_hit(bus_req, MFIO_PORT_A_OUTPUT_LATCH);
    assign rd_a_drive = read_hit(bus_req, MFIO_PORT_A_DRIVE_SELECT);
    assign rd_a_pins = read_hit(bus_req, MFIO_PORT_A_PIN_LEVELS);
    assign rd_b_data = read_hit(bus_req, MFIO_PORT_B_OUTPUT_LATCH);
    assign rd_b_dir = read_hit(bus_req, MFIO_PORT_B_DIRECTION);
    assign rd_c_latch = read_hit(bus_req, MFIO_PORT_C_OUTPUT_LATCH);
    assign rd_c_pins = read_hit(bus_req, MFIO_PORT_C_PIN_LEVELS);

    // Next port A output latch
    always_comb begin
        next_port_a_output_latch = port_a_output_latch;
        if (wr_a_latch) begin
            next_port_a_output_latch = bus_req.wdata; // RQ1
        end
    end

    // Next port A drive select
    always_comb begin
        next_port_a_drive_select = port_a_drive_select;
        if (wr_a_drive) begin
            next_port_a_drive_select = bus_req.wdata; // RQ5
        end
    end

    // Next port B latch; a write-back of a read stores pin levels too
    always_comb begin
        next_port_b_output_latch = port_b_output_latch;
        if (wr_b_latch) begin
            next_port_b_output_latch = bus_req.wdata; // RQ12
        end
    end

    // Next port B direction
    always_comb begin
        next_port_b_direction = port_b_direction;
        if (wr_b_dir) begin
            next_port_b_direction = bus_req.wdata; // RQ9
        end
    end

    // Next port C latch, low bits of the write only
    always_comb begin
        next_port_c_output_latch = port_c_output_latch;
        if (wr_c_latch) begin
            next_port_c_output_latch = bus_req.wdata[MFIO_PORT_C_W-1:0]; // RQ1
        end
    end

    // Port A output latch, all ones at reset
    always_ff @(posedge clk) begin
        if (reset) begin
            port_a_output_latch <= MFIO_PORT_A_LATCH_RESET; // RQ4
        end else begin
            port_a_output_latch <= next_port_a_output_latch;
        end
    end

    // Port A drive select, all open-drain at reset
    always_ff @(posedge clk) begin
        if (reset) begin
            port_a_drive_select <= MFIO_PORT_A_DRIVE_RESET; // RQ4
        end else begin
            port_a_drive_select <= next_port_a_drive_select;
        end
    end

    // Port B output latch; a write-back stores whatever was read, pins included
    always_ff @(posedge clk) begin
        if (reset) begin
            port_b_output_latch <= MFIO_PORT_B_LATCH_RESET; // RQ10
        end else begin
            port_b_output_latch <= next_port_b_output_latch;
        end
    end

    // Port B direction, all inputs at reset
    always_ff @(posedge clk) begin
        if (reset) begin
            port_b_direction <= MFIO_PORT_B_DIR_RESET; // RQ10
        end else begin
            port_b_direction <= next_port_b_direction;
        end
    end

    // Port C output latch, all ones at reset
    always_ff @(posedge clk) begin
        if (reset) begin
            port_c_output_latch <= MFIO_PORT_C_LATCH_RESET; // RQ15
        end else begin
            port_c_output_latch <= next_port_c_output_latch;
        end
    end

    // Port B data read: latch for outputs, live pins for inputs
    assign next_port_b_read = select_bits(port_b_direction, port_b_output_latch, port_b_in); // RQ11

    // Read mux; pins are sampled in the strobe cycle itself
    always_comb begin
        next_rdata = MFIO_READ_IDLE;
        if (rd_a_latch) begin
            next_rdata = port_a_output_latch; // RQ8
        end else if (rd_a_drive) begin
            next_rdata = port_a_drive_select;
        end else if (rd_a_pins) begin
            next_rdata = port_a_in; // RQ2 RQ8
        end else if (rd_b_data) begin
            next_rdata = next_port_b_read; // RQ2
        end else if (rd_b_dir) begin
            next_rdata = port_b_direction;
        end else if (rd_c_latch) begin
            next_rdata = widen_c(port_c_output_latch); // RQ19
        end else if (rd_c_pins) begin
            next_rdata = widen_c(port_c_in); // RQ2 RQ19
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= MFIO_READ_IDLE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Port A: per-pin open-drain or push-pull
    mfio_pin_drive #(
        .WIDTH(MFIO_PORT_A_W)
    ) u_drive_a (
        .latch(port_a_output_latch),
        .push_pull(port_a_drive_select), // RQ5
        .enable({MFIO_PORT_A_W{1'b1}}),
        .out(a_out),
        .oe(a_oe)
    );

    // Port B: push-pull wherever the direction bit is set
    mfio_pin_drive #(
        .WIDTH(MFIO_PORT_B_W)
    ) u_drive_b (
        .latch(port_b_output_latch),
        .push_pull({MFIO_PORT_B_W{1'b1}}),
        .enable(port_b_direction), // RQ9
        .out(b_out),
        .oe(b_oe)
    );

    // Port C pins that the port logic may drive
    always_comb begin
        next_port_c_enable = {MFIO_PORT_C_W{1'b1}};
        if (dual_clock_mode) begin
            next_port_c_enable[MFIO_OSC_IN_BIT] = 1'b0; // RQ17
            next_port_c_enable[MFIO_OSC_OUT_BIT] = 1'b0; // RQ17
        end
        if (stop_mode) begin
            next_port_c_enable[MFIO_STOP_RELEASE_BIT] = 1'b0; // RQ20
        end
    end

    // Port C: sink-only outputs, so a latch of one leaves the pin free
    mfio_pin_drive #(
        .WIDTH(MFIO_PORT_C_W)
    ) u_drive_c (
        .latch(port_c_output_latch),
        .push_pull({MFIO_PORT_C_W{1'b0}}),
        .enable(next_port_c_enable),
        .out(c_out),
        .oe(c_oe)
    );

    // Port A drive gated by the global enable
    always_comb begin
        next_port_a_pins.out = a_out;
        next_port_a_pins.oe = global_output_enable ? a_oe : 8'h00;
    end

    // Port B drive gated by the global enable
    always_comb begin
        next_port_b_pins.out = b_out;
        next_port_b_pins.oe = global_output_enable ? b_oe : 8'h00;
    end

    // Port C drive gated; stop release pin already forced off in stop mode
    always_comb begin
        next_port_c_pins.out = c_out;
        next_port_c_pins.oe = global_output_enable ? c_oe : 3'h0; // RQ20
    end

    // Port A pins registered: a write reaches them one edge after the latch
    always_ff @(posedge clk) begin
        if (reset) begin
            port_a_pins <= '0;
        end else begin
            port_a_pins <= next_port_a_pins; // RQ3
        end
    end

    // Port B pins registered
    always_ff @(posedge clk) begin
        if (reset) begin
            port_b_pins <= '0;
        end else begin
            port_b_pins <= next_port_b_pins; // RQ3
        end
    end

    // Port C pins registered
    always_ff @(posedge clk) begin
        if (reset) begin
            port_c_pins <= '0;
        end else begin
            port_c_pins <= next_port_c_pins; // RQ3
        end
    end

    // Oscillator hookup flag for the upper two port C pins
    always_ff @(posedge clk) begin
        if (reset) begin
            low_freq_osc_connect <= 1'b0;
        end else begin
            low_freq_osc_connect <= dual_clock_mode; // RQ17
        end
    end

    // Falling edge on the stop release pin, driven or not
    mfio_fall_detect u_fall (
        .clk(clk),
        .reset(reset),
        .level(port_c_in[MFIO_STOP_RELEASE_BIT]),
        .fall(c_fall)
    );

    // One-cycle pulse toward the interrupt latch
    always_ff @(posedge clk) begin
        if (reset) begin
            stop_release_fall <= 1'b0;
        end else begin
            stop_release_fall <= c_fall; // RQ18
        end
    end

endmodule : mfio_ports

// file: test/mfio_chk.sv
// Bound checker on the ports of the I/O port block
module mfio_chk
    import mfio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire mfio_bus_req_type bus_req,
    input wire logic [7:0] rdata,
    // Chip controls
    input wire logic global_output_enable,
    input wire logic dual_clock_mode,
    input wire logic stop_mode,
    // Pins and secondary outputs
    input wire logic [7:0] port_a_in,
    input wire mfio_wide_pins_type port_a_pins,
    input wire mfio_wide_pins_type port_b_pins,
    input wire logic [2:0] port_c_in,
    input wire mfio_narrow_pins_type port_c_pins,
    input wire logic low_freq_osc_connect,
    input wire logic stop_release_fall
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Read data and pin sampling
    read_idle_a: assert property (!bus_req.rd |=> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    pin_sample_a: assert property (bus_req.rd && bus_req.addr == 6'h0b |=> rdata == $past(port_a_in))
        else $error("port a pin read not sampled at request");
    c_pin_read_a: assert property (bus_req.rd && bus_req.addr == 6'h0c |=> rdata == {5'h00, $past(port_c_in)})
        else $error("port c pin read wrong");
    latch_back_a: assert property ((bus_req.wr && bus_req.addr == 6'h00) ##1 !bus_req.wr ##1
        (bus_req.rd && bus_req.addr == 6'h00) |=> rdata == $past(bus_req.wdata, 3))
        else $error("port a latch not read back");
    // Pin drive
    dir_drive_a: assert property ((bus_req.wr && bus_req.addr == 6'h09 && global_output_enable) ##1
        (!bus_req.wr && global_output_enable) |=> port_b_pins.oe == $past(bus_req.wdata, 2))
        else $error("port b enable not following direction");
    all_float_a: assert property (!global_output_enable |=> port_a_pins.oe == 8'h00 &&
        port_b_pins.oe == 8'h00 && port_c_pins.oe == 3'h0)
        else $error("pin driven while outputs disabled");
    stop_float_a: assert property (stop_mode |=> !port_c_pins.oe[0])
        else $error("stop pin driven in stop mode");
    osc_pins_a: assert property (dual_clock_mode |=> low_freq_osc_connect && port_c_pins.oe[2:1] == 2'h0)
        else $error("oscillator pins not released");
    // Edge flag
    fall_seen_a: assert property ($fell(port_c_in[0]) |=> stop_release_fall)
        else $error("falling edge not flagged");
    fall_cause_a: assert property (stop_release_fall |-> $past(port_c_in[0], 2) && !$past(port_c_in[0]))
        else $error("edge flag without falling edge");
endmodule : mfio_chk

bind mfio_ports mfio_chk u_chk (.clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
    .global_output_enable(global_output_enable), .dual_clock_mode(dual_clock_mode),
    .stop_mode(stop_mode), .port_a_in(port_a_in), .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins), .port_c_in(port_c_in), .port_c_pins(port_c_pins),
    .low_freq_osc_connect(low_freq_osc_connect), .stop_release_fall(stop_release_fall));

// file: test/mfio_pin_env.sv
// Pad model: each pad follows the block where driven, the outside where released
module mfio_pin_env
    import mfio_pkg::*;
(
    // Block drive
    input wire mfio_wide_pins_type port_a_pins,
    input wire mfio_wide_pins_type port_b_pins,
    input wire mfio_narrow_pins_type port_c_pins,
    // Outside drive
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    input wire logic [2:0] ext_c,
    // Pad levels
    output logic [7:0] port_a_in,
    output logic [7:0] port_b_in,
    output logic [2:0] port_c_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pads take the outside level
    assign port_a_in = (port_a_pins.oe & port_a_pins.out) | (~port_a_pins.oe & ext_a);
    assign port_b_in = (port_b_pins.oe & port_b_pins.out) | (~port_b_pins.oe & ext_b);
    assign port_c_in = (port_c_pins.oe & port_c_pins.out) | (~port_c_pins.oe & ext_c);
endmodule : mfio_pin_env

// file: test/tb.sv
// Self-checking bench for the I/O port block
module tb
    import mfio_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    mfio_bus_req_type req = '0;
    logic goe = 1'b1;
    logic dcm = 1'b0;
    logic stp = 1'b0;
    logic [7:0] ext_a = 8'h00;
    logic [7:0] ext_b = 8'h5a;
    logic [2:0] ext_c = 3'h3;
    logic [7:0] rdata, a_in, b_in;
    logic [2:0] c_in;
    mfio_wide_pins_type pa, pb;
    mfio_narrow_pins_type pc;
    logic osc, fall;
    logic [7:0] n;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    mfio_ports u_dut (.clk(clk), .reset(reset), .bus_req(req), .rdata(rdata),
        .global_output_enable(goe), .dual_clock_mode(dcm), .stop_mode(stp),
        .port_a_in(a_in), .port_a_pins(pa), .port_b_in(b_in), .port_b_pins(pb),
        .port_c_in(c_in), .port_c_pins(pc), .low_freq_osc_connect(osc), .stop_release_fall(fall));
    mfio_pin_env u_env (.port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc), .ext_a(ext_a),
        .ext_b(ext_b), .ext_c(ext_c), .port_a_in(a_in), .port_b_in(b_in), .port_c_in(c_in));

    // Clock and hang guard
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bwr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '0;
    endtask : bwr
    task automatic brd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        chk(rdata, exp);
    endtask : brd
    task automatic settle;
        repeat (3) @(negedge clk);
    endtask : settle
    task automatic count_falls;
        n = 8'h00;
        repeat (6) begin
            @(negedge clk);
            n = n + {7'h00, fall};
        end
    endtask : count_falls

    task automatic t_reset;
        brd(MFIO_PORT_A_OUTPUT_LATCH, 8'hff);
        brd(MFIO_PORT_A_DRIVE_SELECT, 8'h00);
        brd(MFIO_PORT_B_DIRECTION, 8'h00);
        brd(MFIO_PORT_B_OUTPUT_LATCH, 8'h5a);
        brd(MFIO_PORT_C_OUTPUT_LATCH, 8'h07);
        chk(pb.oe, 8'h00);
        chk(pb.out, 8'h00);
        $display("done reset");
    endtask : t_reset
    task automatic t_port_a;
        bwr(MFIO_PORT_A_OUTPUT_LATCH, 8'h33);
        bwr(MFIO_PORT_A_DRIVE_SELECT, 8'h0f);
        settle();
        chk(pa.oe, 8'hcf);
        chk(pa.out, 8'h03);
        brd(MFIO_PORT_A_PIN_LEVELS, 8'h03);
        bwr(MFIO_PORT_A_PIN_LEVELS, 8'h55);
        brd(MFIO_PORT_A_OUTPUT_LATCH, 8'h33);
        brd(6'h3f, 8'h00);
        bwr(MFIO_PORT_A_OUTPUT_LATCH, 8'hff);
        brd(MFIO_PORT_A_OUTPUT_LATCH, 8'hff);
        bwr(MFIO_PORT_A_DRIVE_SELECT, 8'h00);
        settle();
        chk(pa.oe, 8'h00);
        $display("done port a");
    endtask : t_port_a
    task automatic t_port_b;
        @(posedge clk);
        ext_b <= 8'h3c;
        bwr(MFIO_PORT_B_OUTPUT_LATCH, 8'ha5);
        bwr(MFIO_PORT_B_DIRECTION, 8'hf0);
        settle();
        chk(pb.oe, 8'hf0);
        chk(pb.out, 8'ha5);
        brd(MFIO_PORT_B_OUTPUT_LATCH, 8'hac);
        bwr(MFIO_PORT_B_OUTPUT_LATCH, 8'had);
        bwr(MFIO_PORT_B_DIRECTION, 8'hff);
        settle();
        brd(MFIO_PORT_B_OUTPUT_LATCH, 8'had);
        $display("done port b");
    endtask : t_port_b
    task automatic t_port_c;
        bwr(MFIO_PORT_C_OUTPUT_LATCH, 8'hfe);
        settle();
        chk({5'h00, pc.oe}, 8'h01);
        brd(MFIO_PORT_C_OUTPUT_LATCH, 8'h06);
        brd(MFIO_PORT_C_PIN_LEVELS, 8'h02);
        bwr(MFIO_PORT_C_OUTPUT_LATCH, 8'h00);
        stp <= 1'b1;
        settle();
        chk({5'h00, pc.oe}, 8'h06);
        chk({5'h00, pc.out}, 8'h00);
        @(posedge clk);
        dcm <= 1'b1;
        settle();
        chk({4'h0, osc, pc.oe}, 8'h08);
        @(posedge clk);
        stp <= 1'b0;
        dcm <= 1'b0;
        goe <= 1'b0;
        settle();
        chk(pb.oe | {5'h00, pc.oe}, 8'h00);
        @(posedge clk);
        goe <= 1'b1;
        bwr(MFIO_PORT_C_OUTPUT_LATCH, 8'h07);
        $display("done port c");
    endtask : t_port_c
    task automatic t_fall;
        ext_c <= 3'h7;
        settle();
        bwr(MFIO_PORT_C_OUTPUT_LATCH, 8'h06);
        count_falls();
        chk(n, 8'h01);
        bwr(MFIO_PORT_C_OUTPUT_LATCH, 8'h07);
        settle();
        @(posedge clk);
        ext_c <= 3'h6;
        count_falls();
        chk(n, 8'h01);
        $display("done edge flag");
    endtask : t_fall

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_port_a();
        t_port_b();
        t_port_c();
        t_fall();
        close_out();
    end
endmodule : tb
